// file: include/reset_monitor_pkg.sv
// Purpose: shared constants and types for the reset cause flags and clock loss monitor
// Assumes: block clock is the internal oscillator clock at 250 MHz
// Notes:   all offsets, field positions, reset values and timing counts live here

// ==========================================================================
// package
// ==========================================================================
package reset_monitor_pkg;

  // reset cause flag register layout
  localparam int unsigned         FLAGS_WIDTH        = 8;
  localparam int unsigned         WATCHDOG_FLAG_BIT  = 4;
  localparam int unsigned         CLOCK_LOSS_FLAG_BIT = 1;
  localparam int unsigned         UNDERVOLT_FLAG_BIT = 0;
  localparam logic [7:0]          FLAGS_USED_MASK    = 8'h13;
  localparam logic [7:0]          FLAGS_RESET        = 8'h00;

  // clock loss mode register
  localparam int unsigned         CLOCK_LOSS_ENABLE_BIT = 0;
  localparam logic [7:0]          CLOCK_LOSS_MODE_RESET = 8'h00;
  localparam logic [7:0]          CLOCK_LOSS_MODE_MASK  = 8'h01;

  // undervoltage control and level registers
  localparam logic [7:0]          UNDERVOLT_REG_RESET = 8'h00;

  // oscillator halt bit position in the oscillator and cpu clock control registers
  localparam int unsigned         OSC_HALT_BIT = 7;

  // timing
  localparam int unsigned         CLK_PERIOD_PS      = 4000;
  localparam int unsigned         LOSS_TIME_NS       = 32;
  localparam int unsigned         LOSS_CYCLES        = (LOSS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned         SYNC_STAGES        = 2;

  // clock monitor states
  typedef enum logic [2:0] {
    MON_SUSPENDED = 3'b001,
    MON_WATCHING  = 3'b010,
    MON_TRIPPED   = 3'b100
  } mon_state_t;

endpackage

// file: hw/hs_clock_watch.sv
// Purpose: detects a stopped high-speed clock by sampling it on the internal oscillator clock
// Assumes: hs_clk is asynchronous to clk and toggles well within loss_cycles clock periods
// Notes:   lost is a registered level, cleared whenever arm is low

`timescale 1ns/1ps
`default_nettype none

module hs_clock_watch
  import reset_monitor_pkg::*;
#(
  parameter int unsigned LOSS_COUNT = LOSS_CYCLES
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic hs_clk,
  input  wire logic arm,
  output logic      lost
);

  localparam int unsigned CW = $clog2(LOSS_COUNT + 1);

  // ========================================================================
  // elaboration check
  // ========================================================================
  if (LOSS_COUNT < 2) begin : g_bad_count
    $error("hs_clock_watch: LOSS_COUNT must be at least 2");
  end

  // ========================================================================
  // sampling and edge detection
  // ========================================================================
  logic          hs_meta;
  logic          hs_sync;
  logic          hs_prev;
  logic [CW-1:0] idle_count;
  wire           hs_edge   = hs_sync ^ hs_prev;
  wire           count_end = (idle_count == CW'(LOSS_COUNT - 1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hs_meta <= 1'b0;
      hs_sync <= 1'b0;
      hs_prev <= 1'b0;
    end else if (ce) begin
      hs_meta <= hs_clk;
      hs_sync <= hs_meta;
      hs_prev <= hs_sync;
    end
  end

  // ========================================================================
  // idle counter: restarts on every sampled edge
  // ========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_count <= '0;
      lost       <= 1'b0;
    end else if (ce) begin
      if (!arm || hs_edge) begin
        idle_count <= '0;
        lost       <= 1'b0;
      end else if (count_end) begin
        lost <= 1'b1; // R10
      end else begin
        idle_count <= idle_count + CW'(1);
      end
    end
  end

endmodule

`default_nettype wire

// file: hw/reset_source_flags_clock_monitor.sv
// Purpose: reset cause flags, undervoltage register reset policy and clock loss monitor
// Assumes: clk is the internal oscillator clock; source requests are levels in the clk domain
// Notes:   ext_reset_in and power_on_clear are synchronised before use
//
// Overview of operation
// R1 - software reads the reset cause flags as a whole byte only; no writes
// R2 - external reset, power-on clear and any read clear all cause flags
// R3 - bit 4 set means the watchdog requested a reset
// R4 - bit 1 set whenever the clock monitor requests a reset; the code does not set it while an external reset or power-on clear is active
// R5 - bit 0 set when the undervoltage detector requests a reset
// R6 - a zero flag means no request from its source or flags cleared since
// R7 - each reset sets only its own flag; external and power-on clear all
// R8 - software must use a full byte read, never a single-bit read
// R9 - undervoltage registers clear on all resets except an undervoltage reset
// R10 - monitor samples high-speed clock on internal clock, resets when it stops
// R11 - monitoring suspended after reset release until stabilization ends
// R12 - monitoring suspended in stop mode and the following stabilization time
// R13 - suspended while software halts the oscillator, plus following stabilization
// R14 - monitoring suspended while the internal oscillator is stopped
// R15 - a single mode register controls the monitor, resetting to zero
// R16 - enable bit stays set once written; only resets clear it
// R17 - a monitor reset clears the enable bit and sets the clock loss flag
// R18 - enable set while suspended starts monitoring after stabilization ends
// R19 - unused flag bits read zero and are otherwise ignored

`timescale 1ns/1ps
`default_nettype none

module reset_source_flags_clock_monitor
  import reset_monitor_pkg::*;
#(
  parameter int unsigned LOSS_COUNT = LOSS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       ext_reset_in,
  input  wire logic       power_on_clear,
  input  wire logic       watchdog_reset_req,
  input  wire logic       undervoltage_reset_req,
  input  wire logic       hs_clk,
  input  wire logic       stop_mode,
  input  wire logic       osc_settle_done,
  input  wire logic       int_osc_stopped,
  input  wire logic [7:0] main_osc_control_reg,
  input  wire logic [7:0] processor_clock_control_reg,
  input  wire logic       flags_rd,
  output logic      [7:0] flags_rdata,
  input  wire logic       mode_wr,
  input  wire logic [7:0] mode_wdata,
  output logic      [7:0] clock_loss_mode_reg,
  input  wire logic       uv_ctrl_wr,
  input  wire logic [7:0] uv_ctrl_wdata,
  output logic      [7:0] undervoltage_control_reg,
  input  wire logic       uv_level_wr,
  input  wire logic [7:0] uv_level_wdata,
  output logic      [7:0] undervoltage_level_reg,
  output logic            internal_reset,
  output logic            clock_loss_reset,
  output logic            monitor_active
);

  // ========================================================================
  // pin synchronisers
  // ========================================================================
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  wire  [1:0] pin_raw = {power_on_clear, ext_reset_in};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pin_meta[i] <= 1'b0;
        pin_sync[i] <= 1'b0;
      end else if (ce) begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
      end
    end
  end

  wire ext_rst = pin_sync[0];
  wire por_rst = pin_sync[1];

  // ========================================================================
  // reset source decode
  // ========================================================================
  logic clock_loss_trip;

  // flag update: clear, then set each requesting source so a set wins
  function automatic logic [7:0] next_flag_value(
    input logic [7:0] cur,
    input logic       clear_all,
    input logic       wd,
    input logic       loss,
    input logic       uv
  );
    logic [7:0] v;
    v = clear_all ? FLAGS_RESET : cur;
    v[WATCHDOG_FLAG_BIT]   = v[WATCHDOG_FLAG_BIT] | wd;
    v[CLOCK_LOSS_FLAG_BIT] = v[CLOCK_LOSS_FLAG_BIT] | loss;
    v[UNDERVOLT_FLAG_BIT]  = v[UNDERVOLT_FLAG_BIT] | uv;
    return v & FLAGS_USED_MASK;
  endfunction

  wire hard_clear   = ext_rst | por_rst;
  wire src_watchdog = watchdog_reset_req & ~hard_clear;
  wire src_loss     = clock_loss_trip & ~hard_clear;
  wire src_uv       = undervoltage_reset_req & ~hard_clear;
  wire any_reset    = hard_clear | watchdog_reset_req | clock_loss_trip | undervoltage_reset_req;
  wire uv_clear     = hard_clear | watchdog_reset_req | clock_loss_trip;

  // ========================================================================
  // reset cause flags
  // ========================================================================
  logic [7:0] cause_flags;
  wire  [7:0] next_flags = next_flag_value(cause_flags, hard_clear | flags_rd,
                                           src_watchdog, src_loss, src_uv); // R2 R3 R4 R5 R6 R7 R19

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cause_flags <= FLAGS_RESET;
      flags_rdata <= FLAGS_RESET;
    end else if (ce) begin
      cause_flags <= next_flags;
      if (flags_rd) begin
        flags_rdata <= cause_flags & FLAGS_USED_MASK; // R1 R8
      end
    end
  end

  // ========================================================================
  // undervoltage control and level registers
  // ========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      undervoltage_control_reg <= UNDERVOLT_REG_RESET;
      undervoltage_level_reg   <= UNDERVOLT_REG_RESET;
    end else if (ce) begin
      if (uv_clear) begin
        undervoltage_control_reg <= UNDERVOLT_REG_RESET; // R9
        undervoltage_level_reg   <= UNDERVOLT_REG_RESET; // R9
      end else if (!any_reset) begin
        if (uv_ctrl_wr) begin
          undervoltage_control_reg <= uv_ctrl_wdata;
        end
        if (uv_level_wr) begin
          undervoltage_level_reg <= uv_level_wdata;
        end
      end
    end
  end

  // ========================================================================
  // clock loss mode register
  // ========================================================================
  wire enable_now = clock_loss_mode_reg[CLOCK_LOSS_ENABLE_BIT];
  wire enable_set = mode_wr & mode_wdata[CLOCK_LOSS_ENABLE_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clock_loss_mode_reg <= CLOCK_LOSS_MODE_RESET; // R15
    end else if (ce) begin
      if (any_reset) begin
        clock_loss_mode_reg <= CLOCK_LOSS_MODE_RESET; // R16 R17
      end else if (enable_set) begin
        clock_loss_mode_reg <= (clock_loss_mode_reg | mode_wdata) & CLOCK_LOSS_MODE_MASK; // R16
      end
    end
  end

  // ========================================================================
  // suspension tracking
  // ========================================================================
  wire osc_halted = main_osc_control_reg[OSC_HALT_BIT] | processor_clock_control_reg[OSC_HALT_BIT];
  wire suspend_cause = any_reset | stop_mode | osc_halted; // R11 R12 R13
  logic settle_wait;
  logic released;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_wait <= 1'b1;
      released    <= 1'b0;
    end else if (ce) begin
      released <= 1'b1;
      if (suspend_cause || !released) begin
        settle_wait <= 1'b1; // R11 R12 R13
      end else if (osc_settle_done) begin
        settle_wait <= 1'b0; // R18
      end
    end
  end

  // no watching while the oscillator is still settling, whatever started the wait
  wire may_watch = enable_now & ~settle_wait & osc_settle_done & ~suspend_cause & ~int_osc_stopped; // R11 R14 R18

  // ========================================================================
  // clock monitor state machine
  // ========================================================================
  mon_state_t mon_state;
  mon_state_t next_mon_state;
  logic       hs_lost;

  always_comb begin
    next_mon_state = mon_state;
    case (mon_state)
      MON_SUSPENDED: begin
        if (may_watch) begin
          next_mon_state = MON_WATCHING;
        end
      end
      MON_WATCHING: begin
        if (!may_watch) begin
          next_mon_state = MON_SUSPENDED;
        end else if (hs_lost) begin
          next_mon_state = MON_TRIPPED; // R10
        end
      end
      MON_TRIPPED: begin
        next_mon_state = MON_SUSPENDED;
      end
      default: begin
        next_mon_state = MON_SUSPENDED;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mon_state <= MON_SUSPENDED;
    end else if (ce) begin
      mon_state <= next_mon_state;
    end
  end

  assign clock_loss_trip = (mon_state == MON_TRIPPED); // R17
  wire   watching        = (mon_state == MON_WATCHING);

  hs_clock_watch #(
    .LOSS_COUNT (LOSS_COUNT)
  ) u_watch (
    .clk    (clk),
    .nrst   (nrst),
    .ce     (ce),
    .hs_clk (hs_clk),
    .arm    (watching),
    .lost   (hs_lost)
  );

  // ========================================================================
  // outputs
  // ========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      internal_reset   <= 1'b1;
      clock_loss_reset <= 1'b0;
      monitor_active   <= 1'b0;
    end else if (ce) begin
      internal_reset   <= any_reset;
      clock_loss_reset <= clock_loss_trip; // R10
      monitor_active   <= watching;
    end
  end

endmodule

`default_nettype wire

// file: tb/reset_monitor_chk.sv
// Purpose: port-level checks on the reset cause flags and clock loss monitor
// Assumes: one clock domain, nrst asynchronous active low
// Notes:   bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module reset_monitor_chk
  import reset_monitor_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ce,
  input wire logic       watchdog_reset_req,
  input wire logic       stop_mode,
  input wire logic       osc_settle_done,
  input wire logic       int_osc_stopped,
  input wire logic [7:0] main_osc_control_reg,
  input wire logic [7:0] processor_clock_control_reg,
  input wire logic       flags_rd,
  input wire logic [7:0] flags_rdata,
  input wire logic [7:0] clock_loss_mode_reg,
  input wire logic [7:0] undervoltage_control_reg,
  input wire logic       internal_reset,
  input wire logic       clock_loss_reset,
  input wire logic       monitor_active
);
  logic halted;
  assign halted = main_osc_control_reg[OSC_HALT_BIT] | processor_clock_control_reg[OSC_HALT_BIT];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // =====================================================================
  // properties
  sequence s_held(x);
    x [*4];
  endsequence
  property p_unused; flags_rdata[7:5] == 3'h0 && flags_rdata[3:2] == 2'h0; endproperty
  a_unused: assert property (p_unused) else $error("unused flag bits not zero");
  property p_watchdog_rst; ce && watchdog_reset_req |=> internal_reset; endproperty
  a_watchdog_rst: assert property (p_watchdog_rst) else $error("watchdog request gave no reset");
  property p_watchdog_clr; ce && watchdog_reset_req |=> undervoltage_control_reg == 8'h00 && !clock_loss_mode_reg[0]; endproperty
  a_watchdog_clr: assert property (p_watchdog_clr) else $error("watchdog reset kept registers");
  property p_pulse; clock_loss_reset |=> !clock_loss_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("clock loss reset longer than one cycle");
  property p_trip; $rose(clock_loss_reset) |-> ##[0:2] clock_loss_mode_reg == 8'h00; endproperty
  a_trip: assert property (p_trip) else $error("enable kept after clock loss reset");
  property p_sticky; $fell(clock_loss_mode_reg[0]) |-> internal_reset || $past(internal_reset); endproperty
  a_sticky: assert property (p_sticky) else $error("enable cleared without reset");
  property p_stop; s_held(stop_mode) |-> !monitor_active; endproperty
  a_stop: assert property (p_stop) else $error("monitor active in stop mode");
  property p_halt; s_held(halted) |-> !monitor_active; endproperty
  a_halt: assert property (p_halt) else $error("monitor active with oscillator halted");
  property p_osc; s_held(int_osc_stopped) |-> !monitor_active; endproperty
  a_osc: assert property (p_osc) else $error("monitor active with internal clock stopped");
  property p_settle; s_held(!osc_settle_done) |-> !monitor_active; endproperty
  a_settle: assert property (p_settle) else $error("monitor active during stabilization");
  property p_rd; !flags_rd |=> $stable(flags_rdata); endproperty
  a_rd: assert property (p_rd) else $error("read data changed without read");
endmodule
bind reset_source_flags_clock_monitor reset_monitor_chk u_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .watchdog_reset_req(watchdog_reset_req), .stop_mode(stop_mode),
  .osc_settle_done(osc_settle_done), .int_osc_stopped(int_osc_stopped), .main_osc_control_reg(main_osc_control_reg),
  .processor_clock_control_reg(processor_clock_control_reg), .flags_rd(flags_rd), .flags_rdata(flags_rdata),
  .clock_loss_mode_reg(clock_loss_mode_reg), .undervoltage_control_reg(undervoltage_control_reg),
  .internal_reset(internal_reset), .clock_loss_reset(clock_loss_reset), .monitor_active(monitor_active)
);
`default_nettype wire

// file: tb/hs_clock_source.sv
// Purpose: high-speed oscillator model feeding the watched clock
// Assumes: 10 ns period while running
// Notes:   the clock stands still when run is low
`timescale 1ns/1ps
`default_nettype none
module hs_clock_source (
  input  wire logic run,
  output logic      hs_clk
);
  initial hs_clk = 1'b0;
  always #5 if (run) hs_clk = ~hs_clk;
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for the reset cause flags and clock loss monitor
// Assumes: LOSS_COUNT shortened to 4 cycles
// Notes:   expected flags come from the bench model m_flags
`timescale 1ns/1ps
`default_nettype none
module tb
  import reset_monitor_pkg::*;
();
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, ext_reset_in = 1'b0, power_on_clear = 1'b0, hs_run = 1'b1;
  logic watchdog_reset_req = 1'b0, undervoltage_reset_req = 1'b0, stop_mode = 1'b0, osc_settle_done = 1'b1;
  logic int_osc_stopped = 1'b0, flags_rd = 1'b0, mode_wr = 1'b0, uv_ctrl_wr = 1'b0, uv_level_wr = 1'b0;
  logic [7:0] main_osc = 8'h00, proc_clk = 8'h00, wdata = 8'h00, m_flags = 8'h00, m_ctrl, m_level;
  logic [7:0] flags_rdata, clock_loss_mode_reg, undervoltage_control_reg, undervoltage_level_reg;
  logic internal_reset, clock_loss_reset, monitor_active, hs_clk;
  int n_errors = 0, n_checks = 0, seed = 36067, i, k;
  always #2 clk = ~clk;
  hs_clock_source u_hs (.run(hs_run), .hs_clk(hs_clk));
  reset_source_flags_clock_monitor #(.LOSS_COUNT(4)) dut (
    .clk(clk), .nrst(nrst), .ce(ce), .ext_reset_in(ext_reset_in), .power_on_clear(power_on_clear),
    .watchdog_reset_req(watchdog_reset_req), .undervoltage_reset_req(undervoltage_reset_req), .hs_clk(hs_clk),
    .stop_mode(stop_mode), .osc_settle_done(osc_settle_done), .int_osc_stopped(int_osc_stopped),
    .main_osc_control_reg(main_osc), .processor_clock_control_reg(proc_clk), .flags_rd(flags_rd),
    .flags_rdata(flags_rdata), .mode_wr(mode_wr), .mode_wdata(wdata), .clock_loss_mode_reg(clock_loss_mode_reg),
    .uv_ctrl_wr(uv_ctrl_wr), .uv_ctrl_wdata(wdata), .undervoltage_control_reg(undervoltage_control_reg),
    .uv_level_wr(uv_level_wr), .uv_level_wdata(wdata), .undervoltage_level_reg(undervoltage_level_reg),
    .internal_reset(internal_reset), .clock_loss_reset(clock_loss_reset), .monitor_active(monitor_active));
  // =====================================================================
  // tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // byte read only, then the model clears
  task automatic rd(input logic [7:0] exp);
    @(posedge clk);
    flags_rd <= 1'b1;
    @(posedge clk);
    flags_rd <= 1'b0;
    #1 chk("reset_cause_flags", exp, flags_rdata);
    m_flags = 8'h00;
  endtask
  task automatic wr(input int r, input logic [7:0] d);
    @(posedge clk);
    wdata <= d;
    {mode_wr, uv_ctrl_wr, uv_level_wr} <= 3'b100 >> r;
    @(posedge clk);
    {mode_wr, uv_ctrl_wr, uv_level_wr} <= 3'b000;
  endtask
  // 0 watchdog, 1 undervoltage, 2 external, 3 power-on clear
  task automatic src(input int s, input int n);
    @(posedge clk);
    {watchdog_reset_req, undervoltage_reset_req, ext_reset_in, power_on_clear} <= 4'h8 >> s;
    repeat (n) @(posedge clk);
    {watchdog_reset_req, undervoltage_reset_req, ext_reset_in, power_on_clear} <= 4'h0;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic settle();
    @(posedge clk);
    osc_settle_done <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("monitor_active", 8'h00, {7'h0, monitor_active});
    @(posedge clk);
    osc_settle_done <= 1'b1;
    for (i = 0; i < 40 && monitor_active !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    #1 chk("monitor_active", 8'h01, {7'h0, monitor_active});
  endtask
  // =====================================================================
  // tests
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("clock_loss_mode_reg", CLOCK_LOSS_MODE_RESET, clock_loss_mode_reg);
    chk("undervoltage_control_reg", UNDERVOLT_REG_RESET, undervoltage_control_reg);
    rd(m_flags);
    // a request while the clock enable is low must leave no trace
    @(posedge clk);
    {ce, watchdog_reset_req} <= 2'b01;
    repeat (3) @(posedge clk);
    {ce, watchdog_reset_req} <= 2'b10;
    rd(m_flags);
    $display("test reset values done");
    m_ctrl = 8'($random(seed));
    m_level = 8'($random(seed));
    wr(1, m_ctrl);
    wr(2, m_level);
    src(1, 1);
    m_flags |= 8'h01;
    chk("undervoltage_level_reg", m_level, undervoltage_level_reg);
    chk("undervoltage_control_reg", m_ctrl, undervoltage_control_reg);
    rd(m_flags);
    rd(m_flags);
    src(1, 1);
    src(0, 1);
    m_flags |= 8'h11;
    chk("undervoltage_level_reg", 8'h00, undervoltage_level_reg);
    rd(m_flags);
    $display("test source flags done");
    for (k = 2; k < 4; k++) begin
      src(0, 1);
      wr(1, 8'($random(seed)));
      src(k, 3);
      m_flags = 8'h00;
      chk("undervoltage_control_reg", 8'h00, undervoltage_control_reg);
      rd(m_flags);
    end
    $display("test external and power-on clear done");
    wr(0, 8'h01);
    settle();
    wr(0, 8'h00);
    #1 chk("clock_loss_mode_reg", 8'h01, clock_loss_mode_reg);
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      {stop_mode, main_osc[7], proc_clk[7], int_osc_stopped} <= 4'h8 >> k;
      hs_run <= 1'b0;
      repeat (20) @(posedge clk);
      #1 chk("monitor_active", 8'h00, {7'h0, monitor_active});
      chk("clock_loss_mode_reg", 8'h01, clock_loss_mode_reg);
      @(posedge clk);
      {stop_mode, int_osc_stopped, proc_clk} <= 10'h000;
      main_osc <= 8'($random(seed)) & 8'h7f;
      hs_run <= 1'b1;
      settle();
    end
    $display("test monitor suspend done");
    wr(1, 8'($random(seed)));
    @(posedge clk);
    hs_run <= 1'b0;
    for (i = 0; i < 60 && clock_loss_reset !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("clock_loss_reset", 8'h01, {7'h0, clock_loss_reset});
    chk("internal_reset", 8'h01, {7'h0, internal_reset});
    repeat (3) @(posedge clk);
    #1 chk("clock_loss_mode_reg", 8'h00, clock_loss_mode_reg);
    chk("undervoltage_control_reg", 8'h00, undervoltage_control_reg);
    m_flags |= 8'h02;
    rd(m_flags);
    $display("test clock loss trip done");
    stop_test();
  end
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
